/* File: pkg/acgs_consts.svh */
// constants of the channel, gain and code-format sequencer
`ifndef ACGS_CONSTS_SVH
`define ACGS_CONSTS_SVH

`define ACGS_CLK_PERIOD_NS 20
`define ACGS_CONV_TIME_NS 1000

`define ACGS_ADR_CTRL 8'h00
`define ACGS_ADR_STATUS 8'h04
`define ACGS_ADR_RESULT 8'h08
`define ACGS_ADR_COUNT 8'h0c

`define ACGS_CTRL_RESET 1'h1
`define ACGS_CTRL_EN_BIT 0

`define ACGS_ST_CH_LSB 0
`define ACGS_ST_BYP_BIT 3
`define ACGS_ST_GAIN_LSB 4
`define ACGS_ST_BIP_BIT 9
`define ACGS_ST_WIDE_BIT 10
`define ACGS_ST_LPM_BIT 11
`define ACGS_ST_SEQ_BIT 12
`define ACGS_ST_BUSY_BIT 13
`define ACGS_RES_CH_LSB 16

`define ACGS_GAIN_0 5'h01
`define ACGS_GAIN_1 5'h02
`define ACGS_GAIN_2 5'h03
`define ACGS_GAIN_3 5'h04
`define ACGS_GAIN_4 5'h06
`define ACGS_GAIN_5 5'h08
`define ACGS_GAIN_6 5'h0c
`define ACGS_GAIN_7 5'h10
`define ACGS_GAIN_BYPASS 5'h01
`define ACGS_GAIN_WIDE_MIN 5'h02

`endif

/* File: pkg/acgs_pkg.sv */
// types of the channel, gain and code-format sequencer
package acgs_pkg;
    typedef enum logic [1:0]
    {
        ACGS_CV_IDLE = 2'h0,
        ACGS_CV_RUN = 2'h1,
        ACGS_CV_DONE = 2'h3
    } acgs_conv_state_t;

    typedef enum logic
    {
        ACGS_SQ_OFF = 1'h0,
        ACGS_SQ_RUN = 1'h1
    } acgs_seq_state_t;

    typedef struct packed
    {
        logic bypass;
        logic [2:0] code;
    } acgs_gain_t;
endpackage

/* File: pkg/acgs_fmt_if.sv */
// carrier between the sequencer and its output code formatter
`timescale 1ns/1ns
`default_nettype none
interface acgs_fmt_if;
    logic [13:0] raw;
    logic bipolar;
    logic wide;
    logic [13:0] code;
    modport fmt (input raw, input bipolar, input wide, output code);
    modport user (output raw, output bipolar, output wide, input code);
endinterface
`default_nettype wire

/* File: rtl/acgs_code_fmt.sv */
// output code formatter: two's complement or straight binary, 13/14 bit
`timescale 1ns/1ns
`default_nettype none
module acgs_code_fmt
    import acgs_pkg::*;
(
    acgs_fmt_if.fmt f
);
    logic [13:0] twos;

    // raw core code is offset binary, mid-scale at 14'h2000
    assign twos = {~f.raw[13], f.raw[12:0]};

    always_comb
    begin
        if (f.bipolar && f.wide)
        begin
            f.code = twos;
        end
        else if (f.bipolar)
        begin
            // half-scale input: arithmetic halving gives -4096..4095
            f.code = {twos[13], twos[13:1]};
        end
        else
        begin
            // unipolar: unsigned 0..8191 at every gain
            f.code = {1'h0, f.raw[13:1]};
        end
    end
endmodule
`default_nettype wire

/* File: rtl/acgs_sequencer.sv */
// channel sequencer, gain decode, conversion timing and wishbone slave
//
// Function
// R1: sequence-enable high hands channel choice to sequencer at next cs rise.
// R2: sequencer starts at channel 0, steps one per cs rise up to 7.
// R3: while sequencing, the three select inputs are ignored.
// R4: sequencer off: channel equals select inputs, msb first.
// R5: top gain input floating bypasses amplifier, lower gain bits ignored.
// R6: driven gain inputs decode 1,2,3,4,6,8,12,16.
// R7: host must not toggle bypass floating state dynamically.
// R8: host waits 15 us after power-up in bypass before sampling.
// R9: gain may change in operation, sequencer on or off; new gain applies.
// R10: common input floating selects bipolar two's complement codes.
// R11: bipolar with gain two or more gives -8192..8191.
// R12: bipolar bypassed or gain one gives -4096..4095.
// R13: common grounded gives unsigned 0..8191 at every gain.
// R14: after channel 7 the sequencer wraps to channel 0.
// R15: after sequence-enable drops, one more sequenced channel, then pins.
// R16: latched gain applies now in low power, one sample later normally.
// R17: cs falling edge starts a conversion timed internally.
// R18: sequence-enable rising reloads the counter so channel 0 comes first.
// R19: select, gain, enable and mode inputs sampled at cs rise.
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "acgs_consts.svh"
module acgs_sequencer
    import acgs_pkg::*;
#(
    parameter int CONV_TIME_NS = `ACGS_CONV_TIME_NS,
    parameter int CNT_W = 16
)
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic cs_n_i,
    input wire logic sequence_enable_i,
    input wire logic channel_select_msb_i,
    input wire logic channel_select_mid_i,
    input wire logic channel_select_lsb_i,
    input wire logic gain_top_bypass_input_i,
    input wire logic gain_top_floating_i,
    input wire logic gain_select_mid_i,
    input wire logic gain_select_lsb_i,
    input wire logic common_mode_floating_i,
    input wire logic low_power_select_i,
    input wire logic [13:0] core_result_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [2:0] active_channel_o,
    output logic [4:0] gain_factor_o,
    output logic gain_bypass_o,
    output logic conv_busy_o,
    output logic sample_valid_o,
    output logic [13:0] sample_code_o,
    output logic [2:0] sample_channel_o
);
    localparam int CONV_CYC =
        (CONV_TIME_NS + `ACGS_CLK_PERIOD_NS - 1) / `ACGS_CLK_PERIOD_NS;

    generate
        if (CONV_CYC < 1 || CONV_CYC > 4096 || CNT_W < 1 || CNT_W > 32)
        begin : bad_param
            $error("acgs_sequencer: unsupported parameter value");
        end
    endgenerate

    // =========================================================
    // convert-start edge detection
    // =========================================================
    logic cs_n_q;
    logic cs_rise;
    logic cs_fall;

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            cs_n_q <= 1'h0;
        end
        else
        begin
            cs_n_q <= cs_n_i;
        end
    end

    assign cs_rise = cs_n_i & ~cs_n_q;
    assign cs_fall = ~cs_n_i & cs_n_q;

    // =========================================================
    // input sampling at convert-start rise
    // =========================================================
    logic [2:0] pin_channel;
    acgs_gain_t pin_gain;
    logic low_power_select;
    logic bipolar;

    // select pins msb first, all zeros is channel 0
    assign pin_channel = {channel_select_msb_i, channel_select_mid_i,
        channel_select_lsb_i}; // see R4
    assign pin_gain.bypass = gain_top_floating_i; // see R5
    assign pin_gain.code = {gain_top_bypass_input_i, gain_select_mid_i,
        gain_select_lsb_i}; // see R6

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            low_power_select <= 1'h0;
            bipolar <= 1'h0;
        end
        else if (cs_rise)
        begin
            low_power_select <= low_power_select_i; // see R19
            bipolar <= common_mode_floating_i; // see R10
        end
    end

    // =========================================================
    // channel sequencer
    // =========================================================
    acgs_seq_state_t seq_state;
    logic [2:0] seq_ch;
    logic [2:0] active_ch;

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            seq_state <= ACGS_SQ_OFF;
            seq_ch <= 3'h0;
        end
        else if (cs_rise)
        begin
            case (seq_state)
                ACGS_SQ_OFF:
                begin
                    if (sequence_enable_i)
                    begin
                        seq_state <= ACGS_SQ_RUN; // see R1
                        seq_ch <= 3'h0; // see R18
                    end
                end
                ACGS_SQ_RUN:
                begin
                    // wraps 7 -> 0 by width; last step also on drop
                    seq_ch <= seq_ch + 3'h1; // see R2 R14 R15
                    if (!sequence_enable_i)
                    begin
                        seq_state <= ACGS_SQ_OFF;
                    end
                end
                default:
                begin
                    seq_state <= ACGS_SQ_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            active_ch <= 3'h0;
        end
        else if (cs_rise)
        begin
            if (seq_state == ACGS_SQ_OFF && sequence_enable_i)
            begin
                active_ch <= 3'h0; // see R1 R18
            end
            else if (seq_state == ACGS_SQ_RUN)
            begin
                // select pins ignored while sequencing
                active_ch <= seq_ch + 3'h1; // see R3 R15
            end
            else
            begin
                active_ch <= pin_channel; // see R4 R19
            end
        end
    end

    // =========================================================
    // gain latch and decode
    // =========================================================
    acgs_gain_t gain_pend;
    acgs_gain_t gain_app;

    function automatic logic [4:0] gain_value(input acgs_gain_t g);
        logic [4:0] v;
        v = `ACGS_GAIN_BYPASS;
        if (!g.bypass)
        begin
            case (g.code)
                3'h0: v = `ACGS_GAIN_0;
                3'h1: v = `ACGS_GAIN_1;
                3'h2: v = `ACGS_GAIN_2;
                3'h3: v = `ACGS_GAIN_3;
                3'h4: v = `ACGS_GAIN_4;
                3'h5: v = `ACGS_GAIN_5;
                3'h6: v = `ACGS_GAIN_6;
                default: v = `ACGS_GAIN_7;
            endcase
        end
        return v;
    endfunction

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            gain_pend <= '{bypass: 1'h1, code: 3'h0};
            gain_app <= '{bypass: 1'h1, code: 3'h0};
        end
        else if (cs_rise)
        begin
            gain_pend <= pin_gain; // see R9 R19
            if (low_power_select_i)
            begin
                gain_app <= pin_gain; // see R16
            end
            else
            begin
                gain_app <= gain_pend; // see R16
            end
        end
    end

    // =========================================================
    // conversion timing
    // =========================================================
    acgs_conv_state_t conv_state;
    logic [12:0] conv_cnt;
    logic ctrl_en;
    logic [2:0] conv_ch;
    acgs_gain_t conv_gain;
    logic conv_bip;

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            conv_state <= ACGS_CV_IDLE;
            conv_cnt <= 13'h0;
        end
        else
        begin
            case (conv_state)
                ACGS_CV_IDLE:
                begin
                    if (cs_fall && ctrl_en)
                    begin
                        conv_state <= ACGS_CV_RUN; // see R17
                        conv_cnt <= 13'(CONV_CYC - 1);
                    end
                end
                ACGS_CV_RUN:
                begin
                    if (conv_cnt == 13'h0)
                    begin
                        conv_state <= ACGS_CV_DONE;
                    end
                    else
                    begin
                        conv_cnt <= conv_cnt - 13'h1; // see R17
                    end
                end
                ACGS_CV_DONE:
                begin
                    conv_state <= ACGS_CV_IDLE;
                end
                default:
                begin
                    conv_state <= ACGS_CV_IDLE;
                end
            endcase
        end
    end

    // settings frozen for the conversion in flight
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            conv_ch <= 3'h0;
            conv_gain <= '{bypass: 1'h1, code: 3'h0};
            conv_bip <= 1'h0;
        end
        else if (conv_state == ACGS_CV_IDLE && cs_fall && ctrl_en)
        begin
            conv_ch <= active_ch;
            conv_gain <= gain_app;
            conv_bip <= bipolar;
        end
    end

    // =========================================================
    // output code formatting
    // =========================================================
    acgs_fmt_if fmt_bus ();
    logic conv_wide;

    assign conv_wide = conv_bip && !conv_gain.bypass &&
        (gain_value(conv_gain) >= `ACGS_GAIN_WIDE_MIN); // see R11 R12
    assign fmt_bus.raw = core_result_i;
    assign fmt_bus.bipolar = conv_bip; // see R10 R13
    assign fmt_bus.wide = conv_wide;

    acgs_code_fmt u_fmt
    (
        .f(fmt_bus.fmt)
    );

    logic [CNT_W-1:0] sample_cnt;

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            sample_valid_o <= 1'h0;
            sample_code_o <= 14'h0;
            sample_channel_o <= 3'h0;
            sample_cnt <= '0;
        end
        else
        begin
            sample_valid_o <= (conv_state == ACGS_CV_DONE);
            if (conv_state == ACGS_CV_DONE)
            begin
                sample_code_o <= fmt_bus.code; // see R11 R12 R13
                sample_channel_o <= conv_ch;
                sample_cnt <= sample_cnt + 1'b1;
            end
        end
    end

    // =========================================================
    // wishbone slave
    // =========================================================
    logic wb_req;
    logic [31:0] status_word;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_comb
    begin
        status_word = 32'h0;
        status_word[`ACGS_ST_CH_LSB +: 3] = active_ch;
        status_word[`ACGS_ST_BYP_BIT] = gain_app.bypass;
        status_word[`ACGS_ST_GAIN_LSB +: 5] = gain_value(gain_app);
        status_word[`ACGS_ST_BIP_BIT] = bipolar;
        status_word[`ACGS_ST_WIDE_BIT] = conv_wide;
        status_word[`ACGS_ST_LPM_BIT] = low_power_select;
        status_word[`ACGS_ST_SEQ_BIT] = (seq_state == ACGS_SQ_RUN);
        status_word[`ACGS_ST_BUSY_BIT] = (conv_state != ACGS_CV_IDLE);
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            ctrl_en <= `ACGS_CTRL_RESET;
        end
        // write lands at the edge where the master samples ack high
        else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
            wb_sel_i[0] && wb_adr_i == `ACGS_ADR_CTRL)
        begin
            ctrl_en <= wb_dat_i[`ACGS_CTRL_EN_BIT];
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            wb_ack_o <= 1'h0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0;
            if (wb_req && !wb_we_i)
            begin
                if (wb_adr_i == `ACGS_ADR_CTRL)
                begin
                    wb_dat_o <= {31'h0, ctrl_en};
                end
                else if (wb_adr_i == `ACGS_ADR_STATUS)
                begin
                    wb_dat_o <= status_word;
                end
                else if (wb_adr_i == `ACGS_ADR_RESULT)
                begin
                    wb_dat_o <= {13'h0, sample_channel_o, 2'h0,
                        sample_code_o};
                end
                else if (wb_adr_i == `ACGS_ADR_COUNT)
                begin
                    wb_dat_o <= 32'(sample_cnt);
                end
            end
        end
    end

    // =========================================================
    // pin-level outputs
    // =========================================================
    assign active_channel_o = active_ch;
    assign gain_factor_o = gain_value(gain_app);
    assign gain_bypass_o = gain_app.bypass;
    assign conv_busy_o = (conv_state != ACGS_CV_IDLE);
endmodule
`default_nettype wire

/* File: verif/acgs_host_model.sv */
// host-side model driving the converter control pins
`timescale 1ns/1ns
`default_nettype none
module acgs_host_model
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic valid_i,
    output logic cs_n_o,
    output logic seq_en_o,
    output logic [2:0] sel_o,
    output logic [2:0] gain_o,
    output logic gain_float_o,
    output logic com_float_o,
    output logic lpm_o
);
    int up_cyc = 0;
    initial
    begin
        cs_n_o = 1'b0;
        seq_en_o = 1'b0;
        sel_o = 3'h0;
        gain_o = 3'h0;
        gain_float_o = 1'b0;
        com_float_o = 1'b1;
        lpm_o = 1'b1;
    end
    always @(posedge mclk_i)
    begin
        up_cyc <= srst_i ? 0 : up_cyc + 1;
    end
    // pins move only while cs_n is low and hold past the next rise
    task automatic setup(input logic s, input logic [2:0] ch,
        input logic [2:0] g, input logic gf, input logic cf, input logic lp);
        @(posedge mclk_i);
        seq_en_o <= s;
        sel_o <= ch;
        gain_o <= g;
        gain_float_o <= gf;
        com_float_o <= cf;
        lpm_o <= lp;
    endtask
    task automatic take(output logic ok);
        int n;
        ok = 1'b0;
        // bypass level settles for 750 cycles after power-up
        while (up_cyc < 750)
            @(posedge mclk_i);
        @(posedge mclk_i);
        cs_n_o <= 1'b1;
        repeat (3) @(posedge mclk_i);
        cs_n_o <= 1'b0;
        for (n = 0; n < 40 && !ok; n++)
        begin
            @(negedge mclk_i);
            ok = (valid_i === 1'b1);
        end
    endtask
endmodule
`default_nettype wire

/* File: verif/acgs_sequencer_assertions.sv */
// concurrent checks on the sequencer's top-level ports
`timescale 1ns/1ns
`default_nettype none
module acgs_sequencer_assertions
#(
    parameter int CONV_TIME_NS = 1000
)
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic cs_n_i,
    input wire logic common_mode_floating_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [2:0] active_channel_o,
    input wire logic [4:0] gain_factor_o,
    input wire logic gain_bypass_o,
    input wire logic conv_busy_o,
    input wire logic sample_valid_o,
    input wire logic [13:0] sample_code_o
);
    localparam int LO = (CONV_TIME_NS + 19) / 20 + 1;
    localparam int HI = LO + 1;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);
    // ==========================================
    // bus handshake
    a_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    // ==========================================
    // conversion timing
    a_busy_start: assert property (
        $fell(cs_n_i) && !conv_busy_o |=> conv_busy_o)
        else $error("fall did not start conversion");
    a_valid_time: assert property (
        $fell(cs_n_i) && !conv_busy_o |-> ##[LO:HI] sample_valid_o)
        else $error("sample late");
    a_busy_end: assert property (
        $fell(conv_busy_o) |-> sample_valid_o)
        else $error("busy ended without sample");
    a_valid_pulse: assert property (sample_valid_o |=> !sample_valid_o)
        else $error("valid longer than one cycle");
    // ==========================================
    // channel, gain and code range
    a_chan_cause: assert property (
        $changed(active_channel_o) |->
        $past(cs_n_i) && (!$past(cs_n_i, 2) || $past(srst_i, 2)))
        else $error("channel changed without cs rise");
    a_bypass_gain: assert property (
        gain_bypass_o |-> gain_factor_o == 5'h01)
        else $error("bypass gain not one");
    a_gain_legal: assert property (
        gain_factor_o inside {5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08,
        5'h0c, 5'h10})
        else $error("illegal gain value");
    a_narrow_rng: assert property (
        sample_valid_o && common_mode_floating_i && gain_factor_o == 5'h01
        |-> sample_code_o[13] == sample_code_o[12])
        else $error("narrow code out of range");
    a_unip_rng: assert property (
        sample_valid_o && !common_mode_floating_i |-> !sample_code_o[13])
        else $error("unipolar code out of range");
    c_bypass: cover property (sample_valid_o && gain_bypass_o);
    c_unipolar: cover property (sample_valid_o && !common_mode_floating_i);
    c_bus: cover property (wb_ack_o);
endmodule
bind acgs_sequencer acgs_sequencer_assertions
    #(.CONV_TIME_NS(CONV_TIME_NS)) chk (.mclk_i(mclk_i), .srst_i(srst_i),
    .cs_n_i(cs_n_i),
    .common_mode_floating_i(common_mode_floating_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .active_channel_o(active_channel_o), .gain_factor_o(gain_factor_o),
    .gain_bypass_o(gain_bypass_o), .conv_busy_o(conv_busy_o),
    .sample_valid_o(sample_valid_o), .sample_code_o(sample_code_o));
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench of the channel, gain and code-format sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic cs_n, seq_en, gfl, cfl, low_power_select, byp, busy, valid, ack;
    logic [2:0] sel, gain, ach, sch;
    logic [13:0] raw = 14'h0000;
    logic [13:0] code;
    logic [4:0] gfac;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] wsel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    int fails = 0;
    int checked = 0;
    int tick = 0;
    always #10 mclk_i = ~mclk_i;
    acgs_host_model host (.mclk_i(mclk_i), .srst_i(srst_i), .valid_i(valid),
        .cs_n_o(cs_n), .seq_en_o(seq_en), .sel_o(sel), .gain_o(gain),
        .gain_float_o(gfl), .com_float_o(cfl), .lpm_o(low_power_select));
    acgs_sequencer #(.CONV_TIME_NS(100)) uut (.mclk_i(mclk_i),
        .srst_i(srst_i), .cs_n_i(cs_n), .sequence_enable_i(seq_en),
        .channel_select_msb_i(sel[2]), .channel_select_mid_i(sel[1]),
        .channel_select_lsb_i(sel[0]), .gain_top_bypass_input_i(gain[2]),
        .gain_top_floating_i(gfl), .gain_select_mid_i(gain[1]),
        .gain_select_lsb_i(gain[0]), .common_mode_floating_i(cfl),
        .low_power_select_i(low_power_select), .core_result_i(raw), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(wsel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .active_channel_o(ach), .gain_factor_o(gfac), .gain_bypass_o(byp),
        .conv_busy_o(busy), .sample_valid_o(valid), .sample_code_o(code),
        .sample_channel_o(sch));
    task automatic wrap_up;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge mclk_i)
    begin
        tick <= tick + 1;
        if (tick == 20000)
        begin
            fails++;
            wrap_up();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // ==========================================
    // bus access: hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        q = 32'h0;
        @(posedge mclk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wsel <= s;
        wdat <= d;
        for (n = 0; n < 20; n++)
        begin
            @(posedge mclk_i);
            if (ack === 1'b1)
                break;
        end
        q = rdat;
        cmp({31'h0, ack}, 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic smp;
        logic ok;
        host.take(ok);
        cmp({31'h0, ok}, 32'h1);
    endtask
    // ==========================================
    // scenarios
    task automatic t_regs;
        logic [31:0] q;
        wb(1'b0, 8'h00, 4'hf, 32'h0, q);
        cmp(q, 32'h1);
        wb(1'b1, 8'h00, 4'he, 32'h0, q);
        wb(1'b0, 8'h00, 4'hf, 32'h0, q);
        cmp(q, 32'h1);
        wb(1'b1, 8'h10, 4'hf, 32'hffffffff, q);
        wb(1'b0, 8'h10, 4'hf, 32'h0, q);
        cmp(q, 32'h0);
    endtask
    task automatic t_static;
        logic [31:0] q;
        for (int c = 0; c < 8; c++)
        begin
            host.setup(1'b0, 3'(c), 3'h1, 1'b0, 1'b1, 1'b1);
            smp();
            cmp({29'h0, ach}, c);
            cmp({29'h0, sch}, c);
            wb(1'b0, 8'h04, 4'hf, 32'h0, q);
            cmp({29'h0, q[2:0]}, c);
        end
    endtask
    task automatic t_gain;
        logic [4:0] tbl [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08,
            5'h0c, 5'h10};
        logic [31:0] q;
        for (int g = 0; g < 8; g++)
        begin
            host.setup(1'b0, 3'h2, 3'(g), 1'b0, 1'b1, 1'b1);
            smp();
            cmp({27'h0, gfac}, {27'h0, tbl[g]});
            cmp({31'h0, byp}, 32'h0);
        end
        host.setup(1'b0, 3'h2, 3'h6, 1'b1, 1'b1, 1'b1);
        smp();
        cmp({26'h0, byp, gfac}, 32'h21);
        wb(1'b0, 8'h04, 4'hf, 32'h0, q);
        cmp(q, 32'h00000a1a);
    endtask
    task automatic t_fmt;
        logic cf [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
        logic gf [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
        logic [2:0] g [4] = '{3'h1, 3'h1, 3'h0, 3'h7};
        logic [13:0] lo [4] = '{14'h2000, 14'h3000, 14'h3000, 14'h0000};
        logic [13:0] hi [4] = '{14'h1fff, 14'h0fff, 14'h0fff, 14'h1fff};
        logic [31:0] q;
        for (int m = 0; m < 4; m++)
        begin
            @(posedge mclk_i);
            raw <= 14'h0000;
            host.setup(1'b0, 3'h3, g[m], gf[m], cf[m], 1'b1);
            smp();
            cmp({18'h0, code}, {18'h0, lo[m]});
            wb(1'b0, 8'h08, 4'hf, 32'h0, q);
            cmp(q, {13'h0, 3'h3, 2'h0, lo[m]});
            @(posedge mclk_i);
            raw <= 14'h3fff;
            smp();
            cmp({18'h0, code}, {18'h0, hi[m]});
        end
    endtask
    task automatic t_lat;
        host.setup(1'b0, 3'h1, 3'h7, 1'b0, 1'b1, 1'b0);
        smp();
        smp();
        cmp({27'h0, gfac}, 32'h10);
        host.setup(1'b0, 3'h1, 3'h0, 1'b0, 1'b1, 1'b0);
        smp();
        cmp({27'h0, gfac}, 32'h10);
        smp();
        cmp({27'h0, gfac}, 32'h01);
    endtask
    task automatic t_seq;
        logic [31:0] q;
        host.setup(1'b1, 3'h5, 3'h1, 1'b0, 1'b1, 1'b1);
        for (int i = 0; i < 10; i++)
        begin
            smp();
            cmp({29'h0, ach}, i % 8);
        end
        host.setup(1'b0, 3'h5, 3'h1, 1'b0, 1'b1, 1'b1);
        smp();
        cmp({29'h0, ach}, 32'h2);
        smp();
        cmp({29'h0, ach}, 32'h5);
        host.setup(1'b1, 3'h5, 3'h1, 1'b0, 1'b1, 1'b1);
        smp();
        cmp({29'h0, ach}, 32'h0);
        wb(1'b0, 8'h0c, 4'hf, 32'h0, q);
        cmp(q, 32'h0000002a);
    endtask
    initial
    begin
        repeat (10) @(posedge mclk_i);
        srst_i <= 1'b0;
        t_regs();
        t_static();
        t_gain();
        t_fmt();
        t_lat();
        t_seq();
        wrap_up();
    end
endmodule
`default_nettype wire
